// >>> rtl/rtsw_regs.vh
`ifndef RTSW_REGS_VH
`define RTSW_REGS_VH

// register word indices on the bus; byte address is four times the index
`define RTSW_OFS_CTRL      3'h0
`define RTSW_OFS_STAT      3'h1
`define RTSW_OFS_SRQ_VEC   3'h2
`define RTSW_OFS_SSF_VEC   3'h3

// control register field positions
`define RTSW_CTRL_ADDR_LSB 0
`define RTSW_CTRL_ADDR_MSB 4
`define RTSW_CTRL_EN_SRQ   8
`define RTSW_CTRL_EN_BUSY  9
`define RTSW_CTRL_EN_SSF   10
`define RTSW_CTRL_EN_DBC   11
`define RTSW_CTRL_EN_TF    12
`define RTSW_CTRL_EN_BC    13
`define RTSW_CTRL_DBC_ACC  14
`define RTSW_CTRL_SW_BUSY  15
`define RTSW_CTRL_RST      16'h0000

// status word bits (bit time k sits at bit 19-k of the 16-bit field)
`define RTSW_SW_ADDR_MSB   15
`define RTSW_SW_ADDR_LSB   11
`define RTSW_SW_MESSAGE_ERROR_FLAG 10
`define RTSW_SW_INSTR      9
`define RTSW_SW_SRQ        8
`define RTSW_SW_RSV_MSB    7
`define RTSW_SW_RSV_LSB    5
`define RTSW_SW_BC         4
`define RTSW_SW_BUSY       3
`define RTSW_SW_SSF        2
`define RTSW_SW_DBC        1
`define RTSW_SW_TF         0
`define RTSW_STAT_PAR      16

// command word decode values
`define RTSW_BCAST_ADDR    5'h1F
`define RTSW_SA_MODE0      5'h00
`define RTSW_SA_MODE1      5'h1F
`define RTSW_MC_DBC        5'h00
`define RTSW_MC_TX_STATUS  5'h02
`define RTSW_MC_TX_LAST    5'h12
`define RTSW_SYNC_CMD      1'b1

`endif

// >>> rtl/rtsw_status_word.v
// Function
// - word holds sync, five-bit address, status, parity
// - message error flag at bit time nine
// - bad or gapped data sets flag, no reply
// - error flag sent for illegal commands and after bad data words
// - status-keeping mode commands preserve the flag
// - instrumentation bit ten always zero
// - optional service request at bit eleven
// - OR service requests, keep identifying vector word
// - reserved bits twelve to fourteen stay zero
// - broadcast received flag at bit fifteen
// - broadcast reception suppresses reply, sets flag
// - broadcast flag clears on next non-keeping command
// - optional busy flag at bit sixteen
// - busy on transmit sends status alone
// - optional subsystem flag at bit seventeen
// - OR subsystem faults, keep identifying word
// - bus control acceptance at bit eighteen
// - optional terminal fault flag at bit nineteen
// - flags clear per command, persisting ones reset
// - odd parity in last position
`timescale 1ns/10ps
`include "rtsw_regs.vh"

module rtsw_status_word #(
  parameter NSUB = 4  // number of attached subsystems
) (
  input  wire            ref_clk,
  input  wire            rst,
  input  wire            hsel,
  input  wire [31:0]     haddr,
  input  wire [1:0]      htrans,
  input  wire            hwrite,
  input  wire [2:0]      hsize,
  input  wire [31:0]     hwdata,
  input  wire            hready,
  output wire            hreadyout,
  output reg  [31:0]     hrdata,
  output wire            hresp,
  input  wire            cmd_valid,
  input  wire [15:0]     cmd_word,
  input  wire            data_err,
  input  wire            illegal_cmd,
  input  wire            msg_done,
  input  wire [NSUB-1:0] srq_pin,
  input  wire [NSUB-1:0] ssf_pin,
  input  wire            busy_pin,
  input  wire            tf_pin,
  output wire            stat_sync_cmd,
  output reg             stat_tx_req,
  output reg  [15:0]     stat_word,
  output reg             stat_parity,
  output reg             stat_data_en,
  output reg  [15:0]     srq_vec_word,
  output reg  [15:0]     ssf_vec_word
);

  // response machine states, one-hot
  localparam ST_IDLE = 2'b01;  // waiting for a command
  localparam ST_RX   = 2'b10;  // receiving data words of a message

  // build the 16 bits that follow the sync
  function [15:0] fn_word;
    input [4:0] addr;
    input       message_error_flag;
    input       srq;
    input       bc;
    input       busy;
    input       ssf;
    input       dbc;
    input       tf;
    begin
      fn_word = 16'h0000;
      fn_word[`RTSW_SW_ADDR_MSB:`RTSW_SW_ADDR_LSB] = addr;
      fn_word[`RTSW_SW_MESSAGE_ERROR_FLAG] = message_error_flag;
      fn_word[`RTSW_SW_INSTR] = 1'b0;
      fn_word[`RTSW_SW_SRQ]   = srq;
      fn_word[`RTSW_SW_RSV_MSB:`RTSW_SW_RSV_LSB] = 3'h0;
      fn_word[`RTSW_SW_BC]    = bc;
      fn_word[`RTSW_SW_BUSY]  = busy;
      fn_word[`RTSW_SW_SSF]   = ssf;
      fn_word[`RTSW_SW_DBC]   = dbc;
      fn_word[`RTSW_SW_TF]    = tf;
    end
  endfunction

  // odd parity over the 16 bits
  function fn_par;
    input [15:0] w;
    begin
      fn_par = ~(^w);
    end
  endfunction

  // bus side state
  reg  [15:0]       ctrl_q;      // control register
  reg               ap_wr_q;     // write data phase pending
  reg  [2:0]        ap_idx_q;    // word index of pending access
  reg               ap_ok_q;     // pending access hits a mapped word
  // status flags, each a dedicated storage bit, and per-subsystem vectors
  reg               message_error_flag_q;  // sticky message error flag
  reg               srq_q;       // service request
  reg               bc_q;        // broadcast received
  reg               busy_q;      // busy
  reg               ssf_q;       // subsystem flag
  reg               dbc_q;       // bus control accepted
  reg               tf_q;        // terminal fault
  reg  [NSUB-1:0]   srq_vec_q;   // which subsystems asked for service
  reg  [NSUB-1:0]   ssf_vec_q;   // which subsystems report faults
  // response control
  reg  [1:0]        st_q;        // response state
  reg               msg_err_q;   // error seen in current received message
  reg               msg_bc_q;    // current received message is broadcast
  reg               resp_q;      // reply due on next edge
  reg               resp_data_q; // data words may follow the reply
  // synchronised pins
  wire [2*NSUB+1:0] pins_s;
  wire [NSUB-1:0]   srq_s;
  wire [NSUB-1:0]   ssf_s;
  wire              busy_s;
  wire              tf_s;
  // command decode
  wire [4:0]        c_addr;
  wire              c_tx;
  wire [4:0]        c_sa;
  wire [4:0]        c_mc;
  wire              c_mode;
  wire              c_bcast;
  wire              c_keep;
  wire              c_dbc;
  // conditions gated by their enables
  wire              srq_c;
  wire              busy_c;
  wire              ssf_c;
  wire              tf_c;
  wire [NSUB-1:0]   srq_m;
  wire [NSUB-1:0]   ssf_m;
  wire [15:0]       cur_word;
  wire              ap_take;
  wire              ap_ok;

  // pins come from outside the clock domain
  rtsw_sync3 #(
    .W (2*NSUB+2)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     ({tf_pin, busy_pin, ssf_pin, srq_pin}),
    .dout    (pins_s)
  );

  assign srq_s  = pins_s[NSUB-1:0];
  assign ssf_s  = pins_s[2*NSUB-1:NSUB];
  assign busy_s = pins_s[2*NSUB];
  assign tf_s   = pins_s[2*NSUB+1];

  // command fields: address, transmit bit, subaddress, mode code
  assign c_addr  = cmd_word[15:11];
  assign c_tx    = cmd_word[10];
  assign c_sa    = cmd_word[9:5];
  assign c_mc    = cmd_word[4:0];
  assign c_mode  = (c_sa == `RTSW_SA_MODE0) | (c_sa == `RTSW_SA_MODE1);
  assign c_bcast = ctrl_q[`RTSW_CTRL_EN_BC] & (c_addr == `RTSW_BCAST_ADDR);
  // transmit status and transmit last command keep the word
  assign c_keep  = c_mode & c_tx &
                   ((c_mc == `RTSW_MC_TX_STATUS) | (c_mc == `RTSW_MC_TX_LAST));
  assign c_dbc   = c_mode & c_tx & (c_mc == `RTSW_MC_DBC);

  // several subsystems are ORed into one flag each
  assign srq_m  = srq_s & {NSUB{ctrl_q[`RTSW_CTRL_EN_SRQ]}};
  assign ssf_m  = ssf_s & {NSUB{ctrl_q[`RTSW_CTRL_EN_SSF]}};
  assign srq_c  = |srq_m;
  assign ssf_c  = |ssf_m;
  assign busy_c = ctrl_q[`RTSW_CTRL_EN_BUSY] & (busy_s | ctrl_q[`RTSW_CTRL_SW_BUSY]);
  assign tf_c   = ctrl_q[`RTSW_CTRL_EN_TF] & tf_s;

  // sync kind is always the command/status sync
  assign stat_sync_cmd = `RTSW_SYNC_CMD;

  // live status word for software readback
  assign cur_word = fn_word(ctrl_q[`RTSW_CTRL_ADDR_MSB:`RTSW_CTRL_ADDR_LSB],
                            message_error_flag_q, srq_q, bc_q, busy_q, ssf_q, dbc_q, tf_q);

  // status flag storage: cleared by each non-keeping command, refilled by conditions
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      message_error_flag_q <= 1'b0;
      srq_q     <= 1'b0;
      bc_q      <= 1'b0;
      busy_q    <= 1'b0;
      ssf_q     <= 1'b0;
      dbc_q     <= 1'b0;
      tf_q      <= 1'b0;
      srq_vec_q <= {NSUB{1'b0}};
      ssf_vec_q <= {NSUB{1'b0}};
    end else if (cmd_valid & ~c_keep) begin
      // fresh command: clear then set what still holds
      message_error_flag_q <= illegal_cmd | data_err;
      srq_q     <= srq_c;
      bc_q      <= c_bcast & c_tx;
      busy_q    <= busy_c;
      ssf_q     <= ssf_c;
      dbc_q     <= c_dbc & ctrl_q[`RTSW_CTRL_EN_DBC] & ctrl_q[`RTSW_CTRL_DBC_ACC];
      tf_q      <= tf_c;
      srq_vec_q <= srq_m;
      ssf_vec_q <= ssf_m;
    end else begin
      // keeping commands and idle time only add, never clear
      message_error_flag_q <= message_error_flag_q | data_err;
      srq_q     <= srq_q | srq_c;
      busy_q    <= busy_q | busy_c;
      ssf_q     <= ssf_q | ssf_c;
      tf_q      <= tf_q | tf_c;
      srq_vec_q <= srq_vec_q | srq_m;
      ssf_vec_q <= ssf_vec_q | ssf_m;
      // broadcast data accepted without error
      if ((st_q == ST_RX) & msg_done & msg_bc_q & ~msg_err_q & ~data_err) begin
        bc_q <= 1'b1;
      end
    end
  end

  // response decision machine
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q        <= ST_IDLE;
      msg_err_q   <= 1'b0;
      msg_bc_q    <= 1'b0;
      resp_q      <= 1'b0;
      resp_data_q <= 1'b0;
    end else begin
      resp_q <= 1'b0;
      if (cmd_valid) begin
        msg_err_q <= 1'b0;
        msg_bc_q  <= c_bcast;
        if (illegal_cmd) begin
          // illegal command: status with error flag, nothing else
          st_q        <= ST_IDLE;
          resp_q      <= ~c_bcast;
          resp_data_q <= 1'b0;
        end else if (c_tx) begin
          // transmit: reply now, alone when busy or no data word
          st_q        <= ST_IDLE;
          resp_q      <= ~c_bcast;
          // data follow only when the busy bit actually sent is clear
          resp_data_q <= ~(busy_c | (c_keep & busy_q)) & (~c_mode | c_mc[4]);
        end else begin
          // receive: wait for the end of the data words
          st_q        <= ST_RX;
          resp_data_q <= 1'b0;
        end
      end else begin
        case (st_q)
          ST_IDLE: begin
            st_q <= ST_IDLE;
          end
          ST_RX: begin
            if (data_err) begin
              msg_err_q <= 1'b1;
            end
            if (msg_done) begin
              // bad data or gaps withhold the reply
              st_q   <= ST_IDLE;
              resp_q <= ~msg_bc_q & ~msg_err_q & ~data_err;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // reply stage: word is taken from the flags after they settle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stat_tx_req  <= 1'b0;
      stat_word    <= 16'h0000;
      stat_parity  <= 1'b1;
      stat_data_en <= 1'b0;
      srq_vec_word <= 16'h0000;
      ssf_vec_word <= 16'h0000;
    end else begin
      stat_tx_req <= resp_q;
      if (resp_q) begin
        stat_word    <= cur_word;
        stat_parity  <= fn_par(cur_word);
        stat_data_en <= resp_data_q;
      end
      srq_vec_word <= {{(16-NSUB){1'b0}}, srq_vec_q};
      ssf_vec_word <= {{(16-NSUB){1'b0}}, ssf_vec_q};
    end
  end

  // bus slave: zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_take   = hsel & htrans[1] & hready;
  assign ap_ok     = (haddr[31:5] == 27'h0000000) & (haddr[4:2] <= `RTSW_OFS_SSF_VEC);

  // address phase capture and read data
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_wr_q  <= 1'b0;
      ap_idx_q <= 3'h0;
      ap_ok_q  <= 1'b0;
      hrdata   <= 32'h00000000;
    end else begin
      ap_wr_q <= ap_take & hwrite;
      if (ap_take) begin
        ap_idx_q <= haddr[4:2];
        ap_ok_q  <= ap_ok;
      end
      hrdata <= 32'h00000000;
      if (ap_take & ~hwrite & ap_ok) begin
        case (haddr[4:2])
          `RTSW_OFS_CTRL:    hrdata <= {16'h0000, ctrl_q};
          `RTSW_OFS_STAT:    hrdata <= {15'h0000, fn_par(cur_word), cur_word};
          `RTSW_OFS_SRQ_VEC: hrdata <= {{(32-NSUB){1'b0}}, srq_vec_q};
          `RTSW_OFS_SSF_VEC: hrdata <= {{(32-NSUB){1'b0}}, ssf_vec_q};
          default:           hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // control register write in the data phase
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `RTSW_CTRL_RST;
    end else if (ap_wr_q & ap_ok_q & (ap_idx_q == `RTSW_OFS_CTRL)) begin
      ctrl_q <= hwdata[15:0];
    end
  end

  // hsize is fixed at word; other widths are treated as a word
  wire unused_ok = &{1'b0, hsize, htrans[0]};

endmodule // rtsw_status_word

// >>> rtl/rtsw_sync3.v
`timescale 1ns/10ps
// three-stage synchroniser; output follows once stages two and three agree
module rtsw_sync3 #(
  parameter W = 1
) (
  input  wire         ref_clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_q;  // first stage, read only by s2
  reg [W-1:0] s2_q;  // second stage
  reg [W-1:0] s3_q;  // third stage
  integer     i;

  // shift chain and per-bit agreement filter
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // rtsw_sync3

// >>> tb/rtsw_bc_model.sv
`timescale 1ns/10ps
// bus controller stand-in: issues commands and closes receive messages
module rtsw_bc_model (
  input  wire        ref_clk,
  output reg         cmd_valid   = 1'b0,
  output reg  [15:0] cmd_word    = 16'h0000,
  output reg         data_err    = 1'b0,
  output reg         illegal_cmd = 1'b0,
  output reg         msg_done    = 1'b0
);
  // one-cycle command pulse; word inverted after so no stale value lingers
  task send(input [15:0] w, input ill);
    @(posedge ref_clk);
    cmd_valid   <= 1'b1;
    cmd_word    <= w;
    illegal_cmd <= ill;
    @(posedge ref_clk);
    cmd_valid   <= 1'b0;
    cmd_word    <= ~w;
    illegal_cmd <= 1'b0;
  endtask
  // end of received data, with an optional failed word just before
  task finish_rx(input err);
    @(posedge ref_clk);
    data_err <= err;
    @(posedge ref_clk);
    data_err <= 1'b0;
    msg_done <= 1'b1;
    @(posedge ref_clk);
    msg_done <= 1'b0;
  endtask
endmodule // rtsw_bc_model

// >>> tb/rtsw_sva.sv
`timescale 1ns/10ps
// port-level checks on the status word framer
module rtsw_sva (
  input wire        ref_clk,
  input wire        rst,
  input wire        hreadyout,
  input wire        hresp,
  input wire        cmd_valid,
  input wire [15:0] cmd_word,
  input wire        data_err,
  input wire        msg_done,
  input wire        illegal_cmd,
  input wire        stat_sync_cmd,
  input wire        stat_tx_req,
  input wire [15:0] stat_word,
  input wire        stat_parity,
  input wire        stat_data_en
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // addressed transmit command is answered two edges later
  a_tx_reply: assert property (
    cmd_valid && cmd_word[10] && cmd_word[15:11] != 5'h1F |-> ##2 stat_tx_req)
    else $error("transmit command got no reply");
  // reply request is a single-cycle pulse
  a_tx_pulse: assert property (stat_tx_req |=> !stat_tx_req)
    else $error("reply request longer than one cycle");
  // sync kind fixed to command/status, bus always ready and okay
  a_bus_fixed: assert property (stat_sync_cmd && hreadyout && !hresp)
    else $error("fixed outputs moved");
  // broadcast command never draws a reply
  a_bcast_silent: assert property (
    cmd_valid && cmd_word[15:11] == 5'h1F && !$past(cmd_valid) && !$past(msg_done)
    |=> !stat_tx_req [*2])
    else $error("reply to broadcast");
  // failed data word ahead of message end suppresses the reply
  a_err_silent: assert property (msg_done && $past(data_err) |=> !stat_tx_req [*2])
    else $error("reply after bad data word");
  // illegal transmit command replies with the error flag set
  a_illegal_flagged: assert property (
    cmd_valid && illegal_cmd && cmd_word[10] && cmd_word[15:11] != 5'h1F
    |-> ##2 stat_tx_req && stat_word[10])
    else $error("illegal command reply lacks error flag");
  // busy reply goes out without data words
  a_busy_alone: assert property (stat_tx_req && stat_word[3] |-> !stat_data_en)
    else $error("data allowed while busy");
  // instrumentation and reserved positions stay zero
  a_fixed_zero: assert property (!stat_word[9] && stat_word[7:5] == 3'h0)
    else $error("fixed-zero status bit set");
  // word plus parity bit always has an odd count of ones
  a_parity_odd: assert property (^{stat_word, stat_parity})
    else $error("status parity not odd");
  // word only changes together with a reply
  a_word_held: assert property ($changed(stat_word) |-> stat_tx_req)
    else $error("status word changed between replies");
  c_err_reply: cover property (stat_tx_req && stat_word[10]);
  c_bc_reply: cover property (stat_tx_req && stat_word[4]);
  c_busy_reply: cover property (stat_tx_req && stat_word[3]);
endmodule // rtsw_sva

bind rtsw_status_word rtsw_sva u_sva (.ref_clk(ref_clk), .rst(rst), .hreadyout(hreadyout),
  .hresp(hresp), .cmd_valid(cmd_valid), .cmd_word(cmd_word), .data_err(data_err),
  .msg_done(msg_done), .illegal_cmd(illegal_cmd), .stat_sync_cmd(stat_sync_cmd),
  .stat_tx_req(stat_tx_req), .stat_word(stat_word), .stat_parity(stat_parity),
  .stat_data_en(stat_data_en));

// >>> tb/rtsw_tb.sv
`timescale 1ns/10ps
`include "rtsw_regs.vh"
// self-checking bench for the status word framer
module testbench;
  reg         ref_clk  = 1'b0;
  reg         rst      = 1'b1;
  reg         hsel     = 1'b0;
  reg  [31:0] haddr    = 32'h0;
  reg  [1:0]  htrans   = 2'h0;
  reg         hwrite   = 1'b0;
  reg  [2:0]  hsize    = 3'h2;
  reg  [31:0] hwdata   = 32'h0;
  reg  [3:0]  srq_pin  = 4'h0;
  reg  [3:0]  ssf_pin  = 4'h0;
  reg         busy_pin = 1'b0;
  reg         tf_pin   = 1'b0;
  wire        hreadyout, hresp, cmd_valid, data_err, illegal_cmd, msg_done;
  wire        stat_tx_req, stat_parity, stat_data_en;
  wire [31:0] hrdata;
  wire [15:0] cmd_word, stat_word, srq_vec_word, ssf_vec_word;
  integer     err_total    = 0;
  integer     total_checks = 0;
  reg  [31:0] rd;
  // terminal address and subaddresses; modes use 11111
  localparam [4:0] TA = 5'h05, SD = 5'h11, SM = 5'h1F;
  always #25 ref_clk = ~ref_clk;
  rtsw_status_word uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .data_err(data_err), .illegal_cmd(illegal_cmd),
    .msg_done(msg_done), .srq_pin(srq_pin), .ssf_pin(ssf_pin), .busy_pin(busy_pin),
    .tf_pin(tf_pin), .stat_sync_cmd(), .stat_tx_req(stat_tx_req), .stat_word(stat_word),
    .stat_parity(stat_parity), .stat_data_en(stat_data_en),
    .srq_vec_word(srq_vec_word), .ssf_vec_word(ssf_vec_word));
  rtsw_bc_model u_bc (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .data_err(data_err), .illegal_cmd(illegal_cmd), .msg_done(msg_done));
  // expected status word from flag values
  function [15:0] sw(input [4:0] a, input message_error_flag, srq, bc, busy, ssf, dbc, tf);
    sw = {a, message_error_flag, 1'b0, srq, 3'h0, bc, busy, ssf, dbc, tf};
  endfunction
  // command word: address, transmit bit, subaddress, count or mode code
  function [15:0] cw(input [4:0] a, input tr, input [4:0] s, input [4:0] c);
    cw = {a, tr, s, c};
  endfunction
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input ok, input string m);
    total_checks++;
    if (!ok) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // bounded wait for the slave's ready at a rising edge
  task wait_rdy;
    integer n;
    for (n = 0; n < 8; n++) begin
      @(posedge ref_clk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 8) begin
      chk(1'b0, "bus ready timeout");
      report_and_stop;
    end
  endtask
  // one single-word transfer: address phase, then data phase
  task ahb(input wr, input [2:0] idx, input [31:0] d, output [31:0] q);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {27'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  // drive condition pins and let them pass the synchroniser
  task pins(input [3:0] s, input [3:0] f, input b, input t);
    @(posedge ref_clk);
    srq_pin  <= s;
    ssf_pin  <= f;
    busy_pin <= b;
    tf_pin   <= t;
    repeat (6) @(posedge ref_clk);
  endtask
  // reply must arrive two edges on, with word, parity and data enable
  task chk_reply(input [15:0] e, input den, input use_den);
    integer i;
    for (i = 1; i <= 6; i++) begin
      @(posedge ref_clk);
      #1;
      if (stat_tx_req === 1'b1) break;
    end
    if (i > 6) begin
      chk(1'b0, "no status reply");
      report_and_stop;
    end
    chk(i == 1, "reply latency");
    chk(stat_word === e, "status word");
    chk(stat_parity === ~^e, "status parity");
    if (use_den) chk(stat_data_en === den, "data enable");
  endtask
  // no reply may appear for a while
  task chk_silent;
    reg seen;
    seen = 1'b0;
    repeat (5) begin
      @(posedge ref_clk);
      #1;
      seen = seen | (stat_tx_req === 1'b1);
    end
    chk(!seen, "unwanted status reply");
  endtask
  task t_regs;
    ahb(0, `RTSW_OFS_CTRL, 0, rd);
    chk(rd === 32'h0, "control reset value");
    ahb(1, `RTSW_OFS_CTRL, 32'h5, rd);
    ahb(0, `RTSW_OFS_CTRL, 0, rd);
    chk(rd === 32'h5, "control readback");
    ahb(1, `RTSW_OFS_SRQ_VEC, 32'hFFFFFFFF, rd);
    ahb(0, `RTSW_OFS_SRQ_VEC, 0, rd);
    chk(rd === 32'h0, "read-only word written");
    ahb(0, 3'h4, 0, rd);
    chk(rd === 32'h0, "unmapped read");
    $display("test regs done");
  endtask
  // options off: raised conditions must not show
  task t_opts_off;
    pins(4'hF, 4'hF, 1, 1);
    u_bc.send(cw(TA, 1, SD, 2), 0);
    chk_reply(sw(TA, 0, 0, 0, 0, 0, 0, 0), 1, 1);
    $display("test options off done");
  endtask
  task t_flags;
    ahb(1, `RTSW_OFS_CTRL, 32'h3F05, rd);
    pins(4'h4, 4'h2, 1, 1);
    u_bc.send(cw(TA, 1, SD, 2), 0);
    chk_reply(sw(TA, 0, 1, 0, 1, 1, 0, 1), 0, 1);
    chk(srq_vec_word === 16'h0004, "request vector");
    chk(ssf_vec_word === 16'h0002, "fault vector");
    u_bc.send(cw(TA, 1, SM, 5'h10), 0);
    chk_reply(sw(TA, 0, 1, 0, 1, 1, 0, 1), 0, 1);
    pins(4'h0, 4'h0, 0, 0);
    // kept word still shows busy, so no data may follow
    u_bc.send(cw(TA, 1, SM, 5'h12), 0);
    chk_reply(sw(TA, 0, 1, 0, 1, 1, 0, 1), 0, 1);
    u_bc.send(cw(TA, 1, SD, 2), 0);
    chk_reply(sw(TA, 0, 0, 0, 0, 0, 0, 0), 1, 1);
    chk(srq_vec_word === 16'h0000, "request vector cleared");
    $display("test flags done");
  endtask
  task t_rx_err;
    u_bc.send(cw(TA, 0, SD, 2), 0);
    u_bc.finish_rx(1);
    chk_silent;
    u_bc.send(cw(TA, 1, SM, 5'h02), 0);
    chk_reply(sw(TA, 1, 0, 0, 0, 0, 0, 0), 0, 1);
    u_bc.send(cw(TA, 1, SM, 5'h12), 0);
    chk_reply(sw(TA, 1, 0, 0, 0, 0, 0, 0), 1, 1);
    u_bc.send(cw(TA, 0, SD, 2), 0);
    u_bc.finish_rx(0);
    chk_reply(sw(TA, 0, 0, 0, 0, 0, 0, 0), 0, 0);
    $display("test receive error done");
  endtask
  task t_bcast;
    u_bc.send(cw(5'h1F, 0, SD, 2), 0);
    u_bc.finish_rx(0);
    chk_silent;
    u_bc.send(cw(TA, 1, SM, 5'h02), 0);
    chk_reply(sw(TA, 0, 0, 1, 0, 0, 0, 0), 0, 1);
    u_bc.send(cw(TA, 1, SM, 5'h12), 0);
    chk_reply(sw(TA, 0, 0, 1, 0, 0, 0, 0), 1, 1);
    u_bc.send(cw(TA, 1, SD, 2), 0);
    chk_reply(sw(TA, 0, 0, 0, 0, 0, 0, 0), 1, 1);
    $display("test broadcast done");
  endtask
  task t_dbc;
    u_bc.send(cw(TA, 1, SD, 2), 1);
    chk_reply(sw(TA, 1, 0, 0, 0, 0, 0, 0), 0, 0);
    ahb(1, `RTSW_OFS_CTRL, 32'h7F05, rd);
    u_bc.send(cw(TA, 1, SM, 5'h00), 0);
    chk_reply(sw(TA, 0, 0, 0, 0, 0, 1, 0), 0, 1);
    ahb(0, `RTSW_OFS_STAT, 0, rd);
    chk(rd === {15'h0, ~^sw(TA, 0, 0, 0, 0, 0, 1, 0), sw(TA, 0, 0, 0, 0, 0, 1, 0)}, "stat");
    ahb(1, `RTSW_OFS_CTRL, 32'h3F05, rd);
    u_bc.send(cw(TA, 1, SM, 5'h00), 0);
    chk_reply(sw(TA, 0, 0, 0, 0, 0, 0, 0), 0, 1);
    $display("test illegal and bus control done");
  endtask
  // reset, then every scenario in turn
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_opts_off;
    t_flags;
    t_rx_err;
    t_bcast;
    t_dbc;
    report_and_stop;
  end
endmodule // testbench
